// File: design/dscap_pkg.sv
/*
  Constants for the decoder capability bank: register offsets, reset
  values, field positions and the request-sequencer state encoding.
  Assumes the bank sits in the sink configuration space and is served
  by a byte-wide transaction layer on the same core clock.
*/
package dscap_pkg;

  // Bus widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int LEN_W  = 4;
  localparam int NREGS  = 16;

  // Window of the sink_config_space that this bank answers
  localparam logic [19:0] BANK_BASE = 20'h0_0060;
  localparam logic [19:0] BANK_LAST = 20'h0_006F;

  // Register offsets
  localparam logic [19:0] DECOMP_SUPPORT_ADDR   = 20'h0_0060;
  localparam logic [19:0] LINE_BUF_DEPTH_ADDR   = 20'h0_0065;
  localparam logic [19:0] PREDICTION_MODE_ADDR  = 20'h0_0066;
  localparam logic [19:0] COLOUR_FORMAT_ADDR    = 20'h0_0069;
  localparam logic [19:0] COLOUR_DEPTH_ADDR     = 20'h0_006A;
  localparam logic [19:0] PEAK_THROUGHPUT_ADDR  = 20'h0_006B;
  localparam logic [19:0] MAX_SLICE_WIDTH_ADDR  = 20'h0_006C;
  localparam logic [19:0] HIGH_SLICE_COUNT_ADDR = 20'h0_006D;
  localparam logic [19:0] RATE_STEP_ADDR        = 20'h0_006F;

  // Reset (and only) values
  localparam logic [7:0] DECOMP_SUPPORT_RST   = 8'h01;
  localparam logic [7:0] LINE_BUF_DEPTH_RST   = 8'h00;
  localparam logic [7:0] PREDICTION_MODE_RST  = 8'h00;
  localparam logic [7:0] COLOUR_FORMAT_RST    = 8'h17;
  localparam logic [7:0] COLOUR_DEPTH_RST     = 8'h0E;
  localparam logic [7:0] PEAK_THROUGHPUT_RST  = 8'h11;
  localparam logic [7:0] MAX_SLICE_WIDTH_RST  = 8'h08;
  localparam logic [7:0] HIGH_SLICE_COUNT_RST = 8'h00;
  localparam logic [7:0] RATE_STEP_RST        = 8'h00;
  localparam logic [7:0] GAP_RST              = 8'h00;

  // Field positions
  localparam int DECOMP_SUPPORT_BIT  = 0;
  localparam int LINE_BUF_DEPTH_LSB  = 0;
  localparam int BLOCK_PRED_BIT      = 0;
  localparam int NATIVE_422_BIT      = 3;
  localparam int THRU_MODE1_LSB      = 4;
  localparam int RATE_STEP_LSB       = 0;

  // Request sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } dscap_state_type;

  // True when an address falls inside the bank window
  function automatic logic dscap_in_bank(input logic [19:0] addr);
    return (addr >= BANK_BASE) && (addr <= BANK_LAST);
  endfunction : dscap_in_bank

  // Index of an address within the bank window
  function automatic logic [3:0] dscap_index(input logic [19:0] addr);
    logic [19:0] diff;
    diff = addr - BANK_BASE;
    return diff[3:0];
  endfunction : dscap_index

endpackage : dscap_pkg

// File: design/dscap_cap_decode.sv
/*
  Read-data selector for the capability bank: maps a sink_config_space
  address onto one of the sixteen held bytes. Purely combinational;
  the caller registers its outputs.
*/
`timescale 1ns/1ps
`default_nettype none

module dscap_cap_decode
  import dscap_pkg::*;
(
  // Lookup
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  caps [NREGS],
  // Result
  output logic      [7:0]  data,
  output logic             hit
);

  // Outside the window reads zero so a stale byte never leaks out
  always_comb begin
    hit  = dscap_in_bank(addr);
    data = hit ? caps[dscap_index(addr)] : 8'h00;
  end

endmodule : dscap_cap_decode

`default_nettype wire

// File: design/dscap_regs.sv
/*
  Decoder capability bank of the sink configuration space. A byte-wide
  transaction layer on core_clk hands over reads (bursts of up to 16
  bytes) and writes; the bank answers with registered bytes.
  Assumes the requester holds a request until req_ready is seen high.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - 00065h reads 0x00; line buffer depth code 0 means 9 bits.
// - 00066h reads 0x00; block prediction is not supported.
// - 00069h reads 0x17; RGB, 4:4:4, simple 4:2:2, native 4:2:0 only.
// - 0006Ah reads 0x0E; 8, 10 and 12 bits per component.
// - 0006Bh reads 0x11; both throughput modes give 340 MP/s per slice.
// - 0006Ch reads 0x08; widest slice accepted is 2560 pixels.
// - 0006Dh reads 0x00; 16, 20 and 24 slices are not supported.
// - 0006Fh reads 0x00; bits-per-pixel step of one sixteenth.
// - 00060h reads 0x01; the sink can decompress streams.
// - Multi-stream pass-through is not bound by these limits.
module dscap_regs
  import dscap_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Request from the transaction layer
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [19:0] req_addr,
  input  wire logic [3:0]  req_len,
  input  wire logic [7:0]  req_wdata,
  output logic             req_ready,
  // Answer
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_hit,
  output logic             rsp_last,
  output logic             write_ignored,
  // Stream routing
  input  wire logic        mst_passthrough,
  output logic             decoder_limits_on
);

  dscap_state_type state;
  logic [7:0]      caps [NREGS];
  logic [19:0]     cur_addr;
  logic [3:0]      beats_left;
  logic [7:0]      look_data;
  logic            look_hit;
  logic            take;
  logic            unused_wdata;

  assign take         = req_valid && req_ready;
  assign unused_wdata = ^req_wdata;

  // Capability bytes: loaded at reset, with no write path at all
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NREGS; i++) begin
        caps[i] <= GAP_RST;
      end
      caps[dscap_index(DECOMP_SUPPORT_ADDR)]   <= DECOMP_SUPPORT_RST;
      caps[dscap_index(LINE_BUF_DEPTH_ADDR)]   <= LINE_BUF_DEPTH_RST;
      caps[dscap_index(PREDICTION_MODE_ADDR)]  <= PREDICTION_MODE_RST;
      caps[dscap_index(COLOUR_FORMAT_ADDR)]    <= COLOUR_FORMAT_RST;
      caps[dscap_index(COLOUR_DEPTH_ADDR)]     <= COLOUR_DEPTH_RST;
      caps[dscap_index(PEAK_THROUGHPUT_ADDR)]  <= PEAK_THROUGHPUT_RST;
      caps[dscap_index(MAX_SLICE_WIDTH_ADDR)]  <= MAX_SLICE_WIDTH_RST;
      caps[dscap_index(HIGH_SLICE_COUNT_ADDR)] <= HIGH_SLICE_COUNT_RST;
      caps[dscap_index(RATE_STEP_ADDR)]        <= RATE_STEP_RST;
    end
  end

  // Address lookup shared by every read beat
  dscap_cap_decode u_decode (
    .addr (cur_addr),
    .caps (caps),
    .data (look_data),
    .hit  (look_hit)
  );

  // Request sequencer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      cur_addr   <= 20'h0_0000;
      beats_left <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (take) begin
            cur_addr   <= req_addr;
            beats_left <= req_len;
            state      <= req_write ? ST_WRITE : ST_READ;
          end
        end
        ST_READ: begin
          // Burst walks upward one byte per cycle
          cur_addr   <= cur_addr + 20'h0_0001;
          beats_left <= beats_left - 4'h1;
          if (beats_left == 4'h0) begin
            state <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          // Nothing to store: the acknowledge alone is owed
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Ready drops as soon as a request is taken, returns with the last beat
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_ready <= 1'b0;
    end else if (state == ST_IDLE) begin
      req_ready <= !take;
    end else if (state == ST_WRITE) begin
      req_ready <= 1'b1;
    end else begin
      req_ready <= (beats_left == 4'h0);
    end
  end

  // Answer bytes, registered so outputs never glitch
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid     <= 1'b0;
      rsp_data      <= 8'h00;
      rsp_hit       <= 1'b0;
      rsp_last      <= 1'b0;
      write_ignored <= 1'b0;
    end else begin
      rsp_valid     <= (state == ST_READ) || (state == ST_WRITE);
      rsp_data      <= (state == ST_READ) ? look_data : 8'h00;
      rsp_hit       <= (state != ST_IDLE) && look_hit;
      rsp_last      <= (state == ST_WRITE) ||
                       ((state == ST_READ) && (beats_left == 4'h0));
      // Data is dropped; the ack still goes out so the source moves on
      write_ignored <= (state == ST_WRITE) && look_hit;
    end
  end

  // Limits apply only when the decoder is actually in the path
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      decoder_limits_on <= 1'b1;
    end else begin
      decoder_limits_on <= !mst_passthrough;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Each capability byte shows one cycle after its address is looked up
  line_buf_read_a: assert property (
    (state == ST_READ && cur_addr == LINE_BUF_DEPTH_ADDR)
      |=> rsp_valid && rsp_hit && rsp_data == 8'h00)
    else $error("line buffer depth byte wrong");

  pred_read_a: assert property (
    (state == ST_READ && cur_addr == PREDICTION_MODE_ADDR)
      |=> rsp_data[BLOCK_PRED_BIT] == 1'b0 && rsp_data == 8'h00)
    else $error("block prediction advertised");

  colour_fmt_a: assert property (
    (state == ST_READ && cur_addr == COLOUR_FORMAT_ADDR)
      |=> rsp_data == 8'h17 && !rsp_data[NATIVE_422_BIT])
    else $error("colour format byte wrong");

  colour_depth_a: assert property (
    (state == ST_READ && cur_addr == COLOUR_DEPTH_ADDR)
      |=> rsp_data == 8'h0E)
    else $error("colour depth byte wrong");

  throughput_a: assert property (
    (state == ST_READ && cur_addr == PEAK_THROUGHPUT_ADDR)
      |=> rsp_data[3:0] == 4'h1 && rsp_data[7:4] == 4'h1)
    else $error("throughput byte wrong");

  slice_width_a: assert property (
    (state == ST_READ && cur_addr == MAX_SLICE_WIDTH_ADDR)
      |=> rsp_data == 8'h08)
    else $error("slice width byte wrong");

  slice_count_a: assert property (
    (state == ST_READ && cur_addr == HIGH_SLICE_COUNT_ADDR)
      |=> rsp_data == 8'h00)
    else $error("high slice count advertised");

  rate_step_a: assert property (
    (state == ST_READ && cur_addr == RATE_STEP_ADDR)
      |=> rsp_data[2:0] == 3'h0 && rsp_data == 8'h00)
    else $error("rate step byte wrong");

  decomp_read_a: assert property (
    (state == ST_READ && cur_addr == DECOMP_SUPPORT_ADDR)
      |=> rsp_data == 8'h01 && rsp_last == ($past(beats_left) == 4'h0))
    else $error("decompression support byte wrong");

  passthru_lim_a: assert property (
    mst_passthrough |=> !decoder_limits_on)
    else $error("limits applied to pass-through");

  write_noeffect_a: assert property (
    (take && req_write) |=> ##1 rsp_valid && rsp_last && req_ready
      && caps[dscap_index(COLOUR_FORMAT_ADDR)] == COLOUR_FORMAT_RST)
    else $error("write not acked or altered a value");

  burst_len_a: assert property (
    (take && !req_write && req_len == 4'h3)
      |=> ##1 (rsp_valid && !rsp_last) [*3] ##1 (rsp_valid && rsp_last))
    else $error("burst length wrong");

  // Handshake: ready is high only while idle, so a busy bank refuses
  ready_idle_a: assert property (
    req_ready |-> state == ST_IDLE)
    else $error("ready raised while busy");

  take_ready_a: assert property (
    take |=> !req_ready)
    else $error("ready still high after a take");

  idle_ready_a: assert property (
    (state == ST_IDLE && !take) |=> req_ready)
    else $error("ready low while idle");

  // A taken read starts at the requested byte with the requested length
  start_addr_a: assert property (
    (take && !req_write)
      |=> state == ST_READ && cur_addr == $past(req_addr) && beats_left == $past(req_len))
    else $error("read started at the wrong byte");

  // Every beat but the last keeps ready low and walks up one byte
  mid_burst_a: assert property (
    (state == ST_READ && beats_left != 4'h0)
      |=> state == ST_READ && !req_ready && rsp_valid && !rsp_last
        && cur_addr == $past(cur_addr) + 20'h0_0001)
    else $error("burst stalled or skipped a byte");

  burst_end_a: assert property (
    (state == ST_READ && beats_left == 4'h0)
      |=> state == ST_IDLE && req_ready && rsp_valid && rsp_last)
    else $error("burst did not end cleanly");

  // No beat, flag or stray data while the sequencer rests
  idle_quiet_a: assert property (
    state == ST_IDLE
      |=> !rsp_valid && !rsp_last && !write_ignored && rsp_data == 8'h00)
    else $error("answer beat with no request");

  hit_valid_a: assert property (
    rsp_hit |-> rsp_valid)
    else $error("hit flag outside a beat");

  // Window decode: bank bytes flagged, gaps and outside bytes read zero
  hit_flag_a: assert property (
    (state == ST_READ && cur_addr >= BANK_BASE && cur_addr <= BANK_LAST)
      |=> rsp_valid && rsp_hit)
    else $error("byte inside the bank not flagged");

  miss_zero_a: assert property (
    (state == ST_READ && (cur_addr < BANK_BASE || cur_addr > BANK_LAST))
      |=> rsp_valid && !rsp_hit && rsp_data == 8'h00)
    else $error("byte outside the bank not zero");

  gap_zero_a: assert property (
    (state == ST_READ && ((cur_addr > BANK_BASE && cur_addr < LINE_BUF_DEPTH_ADDR)
      || cur_addr == 20'h0_0067 || cur_addr == 20'h0_0068 || cur_addr == 20'h0_006E))
      |=> rsp_hit && rsp_data == GAP_RST)
    else $error("unused byte in the bank not zero");

  // A write costs one beat and drops its data
  write_single_a: assert property (
    state == ST_WRITE |=> (state == ST_IDLE && req_ready) ##1 !rsp_valid)
    else $error("write held the sequencer");

  write_drop_a: assert property (
    write_ignored |-> rsp_valid && rsp_last && rsp_hit && rsp_data == 8'h00)
    else $error("write drop flag without a clean acknowledge");

  // Limits come back as soon as pass-through ends
  limits_back_a: assert property (
    !mst_passthrough |=> decoder_limits_on)
    else $error("limits not restored after pass-through");

  // Main scenarios the bench should reach
  read_burst_c:  cover property (take && !req_write && req_len == 4'hF);
  short_burst_c: cover property (take && !req_write && req_len == 4'h3);
  write_c:       cover property (write_ignored);
  miss_c:        cover property (rsp_valid && !rsp_hit);
  passthru_c:    cover property ($fell(decoder_limits_on));

endmodule : dscap_regs

`default_nettype wire

// File: tb/dscap_src_model.sv
/*
  Source-side requester for the capability bank: drives one request at
  a time and logs each answer beat with its cycle. Assumes a bench that
  calls xfer and owns the clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module dscap_src_model (
  // Clock
  input  wire logic        core_clk,
  // Request
  output logic             req_valid,
  output logic             req_write,
  output logic [19:0]      req_addr,
  output logic [3:0]       req_len,
  output logic [7:0]       req_wdata,
  input  wire logic        req_ready,
  // Answer
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_data,
  input  wire logic        rsp_hit,
  input  wire logic        rsp_last,
  input  wire logic        write_ignored
);
  int          cyc = 0;
  logic [10:0] beat [$];
  int          bcyc [$];

  // Idle request at time zero
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = 20'h0_0000;
    req_len   = 4'h0;
    req_wdata = 8'h00;
  end

  // Cycle count on rising edges; beats logged mid-cycle, once settled
  always @(posedge core_clk) cyc <= cyc + 1;
  always @(negedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      beat.push_back({rsp_hit, rsp_last, write_ignored, rsp_data});
      bcyc.push_back(cyc);
    end
  end

  // One request, held until ready is seen, then released
  task automatic xfer(input logic wr, input logic [19:0] a, input logic [3:0] n,
                      output int tk);
    int k;
    beat.delete();
    bcyc.delete();
    @(negedge core_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_len   = n;
    req_wdata = 8'hA5;
    k = 0;
    while (req_ready !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    tk = cyc;
    @(negedge core_clk);
    req_valid = 1'b0;
    // Released lines must not keep their last value
    req_addr  = ~a;
    req_len   = ~n;
    req_wdata = 8'h5A;
    repeat (int'(n) + 3) @(negedge core_clk);
    @(posedge core_clk);
  endtask : xfer
endmodule : dscap_src_model

`default_nettype wire

// File: tb/dscap_regs_bench.sv
/*
  Self-checking bench for the capability bank. Assumes the source model
  drives requests at falling edges; core_clk runs at 200 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module dscap_regs_bench;
  logic        core_clk = 1'b0;
  logic        arst_n, mst_passthrough, decoder_limits_on;
  logic        req_valid, req_write, req_ready;
  logic        rsp_valid, rsp_hit, rsp_last, write_ignored;
  logic [19:0] req_addr;
  logic [3:0]  req_len;
  logic [7:0]  req_wdata, rsp_data;
  int          err_count = 0;
  int          cmp_count = 0;
  logic [19:0] wr_addr [6] = '{20'h0_0060, 20'h0_0065, 20'h0_0069,
                               20'h0_006C, 20'h0_006F, 20'h0_0070};

  // Clock at 5 ns period
  initial forever #2.5 core_clk = ~core_clk;

  dscap_regs DUT (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_len(req_len),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_hit(rsp_hit), .rsp_last(rsp_last),
    .write_ignored(write_ignored), .mst_passthrough(mst_passthrough),
    .decoder_limits_on(decoder_limits_on));

  dscap_src_model SRC (.core_clk(core_clk), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_len(req_len),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_hit(rsp_hit), .rsp_last(rsp_last),
    .write_ignored(write_ignored));

  // Expected capability bytes; gaps and outside addresses read zero
  function automatic logic [7:0] exp_val(input logic [19:0] a);
    case (a)
      20'h0_0060: return 8'h01;
      20'h0_0069: return 8'h17;
      20'h0_006A: return 8'h0E;
      20'h0_006B: return 8'h11;
      20'h0_006C: return 8'h08;
      default:    return 8'h00;
    endcase
  endfunction : exp_val

  function automatic logic in_bank(input logic [19:0] a);
    return a >= 20'h0_0060 && a <= 20'h0_006F;
  endfunction : in_bank

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // Burst read with beat values, flags and spacing
  task automatic check_read(input logic [19:0] a, input logic [3:0] n);
    int tk;
    logic [19:0] b;
    SRC.xfer(1'b0, a, n, tk);
    chk(SRC.beat.size(), int'(n) + 1, "beat count");
    for (int i = 0; i <= int'(n); i++) begin
      b = a + 20'(i);
      chk(SRC.beat[i], {in_bank(b), i == int'(n), 1'b0, exp_val(b)}, "read beat");
      chk(SRC.bcyc[i], tk + 2 + i, "beat timing");
    end
  endtask : check_read

  task automatic t_reset;
    arst_n = 1'b0;
    mst_passthrough = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({req_ready, rsp_valid, rsp_last, write_ignored, decoder_limits_on}, 5'h01, "reset");
    arst_n = 1'b1;
    @(negedge core_clk);
    chk(req_ready, 1'b1, "ready after reset");
  endtask : t_reset

  task automatic t_singles;
    for (int i = 0; i < 16; i++) begin
      check_read(20'h0_0060 + 20'(i), 4'h0);
    end
  endtask : t_singles

  // Full bank, then a burst running past the window
  task automatic t_burst;
    check_read(20'h0_0060, 4'hF);
    check_read(20'h0_0068, 4'hF);
    check_read(20'h0_0069, 4'h3);
  endtask : t_burst

  // Writes are acked once and leave every value alone
  task automatic t_write;
    int tk;
    logic h;
    foreach (wr_addr[i]) begin
      SRC.xfer(1'b1, wr_addr[i], 4'h3, tk);
      h = in_bank(wr_addr[i]);
      chk(SRC.beat.size(), 1, "write beat count");
      chk(SRC.beat[0], {h, 1'b1, h, 8'h00}, "write ack");
      check_read(wr_addr[i], 4'h0);
    end
  endtask : t_write

  // Pass-through lifts the limits; reads stay unchanged
  task automatic t_mst;
    @(negedge core_clk);
    mst_passthrough = 1'b1;
    @(negedge core_clk);
    chk(decoder_limits_on, 1'b0, "limits in pass-through");
    check_read(20'h0_006C, 4'h0);
    @(negedge core_clk);
    mst_passthrough = 1'b0;
    @(negedge core_clk);
    chk(decoder_limits_on, 1'b1, "limits restored");
  endtask : t_mst

  task automatic close_out;
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #50000;
    err_count++;
    close_out();
  end

  initial begin
    t_reset();
    t_singles();
    t_burst();
    t_write();
    t_mst();
    close_out();
  end
endmodule : dscap_regs_bench

`default_nettype wire
